// File: core/fdc_arbiter.v
// fixed priority pick among pending channel requests
module fdc_arbiter #(
	parameter CHANNELS = 4,
	parameter IW = 2
) (
	input wire [CHANNELS-1:0] pend_i,
	output reg [IW-1:0] grant_idx_o,
	output reg grant_valid_o
);
	integer k;

	// scan from the top so the lowest number wins last
	always @* begin
		grant_idx_o = {IW{1'b0}};
		grant_valid_o = 1'b0;
		for (k = CHANNELS - 1; k >= 0; k = k - 1) begin
			if (pend_i[k]) begin
				grant_idx_o = k[IW-1:0];
				grant_valid_o = 1'b1;
			end
		end
	end
endmodule // fdc_arbiter

// File: core/fdc_consts.vh
// shared constants for the four-channel transfer controller
`ifndef FDC_CONSTS_VH
`define FDC_CONSTS_VH
`define FDC_SRC_EXT_EXTERNAL_INTERRUPT0 8'h00
`define FDC_SRC_CAPTURE1 8'h01
`define FDC_SRC_COMPARE1 8'h02
`define FDC_SRC_SERIAL1_RX 8'h0b
`define FDC_SRC_SERIAL1_TX 8'h0c
`define FDC_SRC_CONV_DONE 8'h0d
`define FDC_SRC_CAN1_RX 8'h22
`define FDC_ADDR_CAPTURE1 16'h0144
`define FDC_ADDR_COMPARE1_PRI 16'h0906
`define FDC_ADDR_COMPARE1_SEC 16'h0904
`define FDC_ADDR_SERIAL1_RX 16'h0226
`define FDC_ADDR_SERIAL1_TX 16'h0224
`define FDC_ADDR_CAN1_RX 16'h0440
`define FDC_ADDR_CONV_RES0 16'h0300
`define FDC_AM_POSTINC 2'h0
`define FDC_AM_NOINC 2'h1
`define FDC_AM_PERIPH 2'h2
`define FDC_ST_IDLE 2'h0
`define FDC_ST_READ 2'h1
`define FDC_ST_WRITE 2'h2
`define FDC_ST_DONE 2'h3
`define FDC_SYNC_ZERO 3'h0
`define FDC_SYNC_ONES 3'h7
`endif

// File: core/fdc_dma.v
// four-channel block transfer controller between sram and peripherals
// Operation
// - each channel moves data one direction only
// - fixed channel priority picks among pending requests
// - interrupt the cpu when a block completes
// - interrupt also at half block
// - post-increment mode advances sram address
// - no-increment mode holds the sram address
// - peripheral indirect mode uses supplied address
// - byte or word transfer per channel
// - start on manual or peripheral request
// - one-shot stops, save that a request in its final cycle still starts one more element; auto-repeat restarts block
// - ping-pong alternates two sram start addresses
// - request source selectable from interrupt lines
// - select code zero means external interrupt 0
`include "fdc_consts.vh"
module fdc_dma #(
	parameter CH = 4,
	parameter IW = 2,
	parameter AW = 16,
	parameter DW = 16,
	parameter CW = 16,
	parameter NSRC = 256,
	parameter FIFO_DEPTH = 8,
	parameter FIFO_AW = 3
) (
	input wire core_clk_i,
	input wire reset_i,
	input wire ce_i,
	// per-channel configuration, packed channel 0 in the low bits
	input wire [CH-1:0] chan_enable_i,
	input wire [CH-1:0] chan_to_periph_i,
	input wire [CH-1:0] chan_byte_mode_i,
	input wire [CH*2-1:0] chan_addr_mode_i,
	input wire [CH-1:0] chan_auto_repeat_i,
	input wire [CH-1:0] chan_ping_pong_i,
	input wire [CH-1:0] chan_half_irq_i,
	input wire [CH*8-1:0] request_source_select_i,
	input wire [CH*AW-1:0] chan_sram_start_a_i,
	input wire [CH*AW-1:0] chan_sram_start_b_i,
	input wire [CH*AW-1:0] channel_peripheral_address_i,
	input wire [CH*CW-1:0] chan_count_i,
	input wire [CH-1:0] chan_manual_req_i,
	// interrupt source lines from peripherals, asynchronous
	input wire [NSRC-1:0] irq_src_i,
	input wire [AW-1:0] periph_supplied_addr_i,
	// memory-side master port
	output reg mem_rd_o,
	output reg mem_wr_o,
	output reg mem_byte_o,
	output reg [AW-1:0] mem_addr_o,
	output reg [DW-1:0] mem_wdata_o,
	input wire [DW-1:0] mem_rdata_i,
	input wire mem_ack_i,
	// status
	output reg [CH-1:0] chan_busy_o,
	output reg [CH-1:0] chan_half_irq_o,
	output reg [CH-1:0] chan_done_irq_o,
	output reg [CH-1:0] chan_ping_sel_o
);
	reg [1:0] state_reg;
	reg [IW-1:0] cur_reg;
	reg [CH-1:0] pend_reg;
	reg [CH-1:0] active_reg;
	reg [CH*AW-1:0] offs_reg;
	reg [CH*CW-1:0] done_cnt_reg;
	reg [CH-1:0] ping_reg;
	reg [CH-1:0] manual_prev_reg;
	reg [NSRC-1:0] sync1_reg;
	reg [NSRC-1:0] sync2_reg;
	reg [NSRC-1:0] sync3_reg;
	reg [NSRC-1:0] src_lvl_reg;
	reg [NSRC-1:0] src_prev_reg;
	wire [NSRC-1:0] src_rise;
	wire [CH-1:0] hw_req;
	wire [IW-1:0] grant_idx;
	wire grant_valid;
	reg [AW-1:0] sram_addr;
	reg [AW-1:0] step;
	reg [CW-1:0] cnt_now;
	reg [CW-1:0] cnt_tot;
	reg [AW-1:0] src_addr;
	reg [AW-1:0] dst_addr;
	wire fifo_in_ready;
	wire [DW-1:0] fifo_out_data;
	wire fifo_out_valid;
	reg fifo_push;
	reg fifo_pop;
	// one-hot of the channel whose element retires this cycle
	reg [CH-1:0] retire_mask;
	// element bookkeeping for the channel in service
	reg [CW-1:0] elem_next;
	reg half_hit;
	reg block_end;
	reg [AW-1:0] offs_next;
	// selected configuration of the channel in service
	reg cur_byte;
	reg cur_to_periph;
	reg [1:0] cur_mode;
	reg [AW-1:0] cur_pad;
	// finished one-shot channels, held off until re-enabled
	reg [CH-1:0] halt_reg;
	wire [CH-1:0] req_new;
	wire [CH-1:0] pend_next;
	genvar g;

	// three-stage synchroniser, change taken when stages two and three agree
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			sync1_reg <= {NSRC{1'b0}};
			sync2_reg <= {NSRC{1'b0}};
			sync3_reg <= {NSRC{1'b0}};
			src_lvl_reg <= {NSRC{1'b0}};
			src_prev_reg <= {NSRC{1'b0}};
		end else if (ce_i) begin
			sync1_reg <= irq_src_i;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			src_lvl_reg <= (sync2_reg & sync3_reg) |
				(src_lvl_reg & (sync2_reg | sync3_reg));
			src_prev_reg <= src_lvl_reg;
		end
	end
	assign src_rise = src_lvl_reg & ~src_prev_reg;

	// any interrupt line may be a channel's trigger, code 00 is ext int 0
	generate
		for (g = 0; g < CH; g = g + 1) begin : g_req
			assign hw_req[g] =
				src_rise[request_source_select_i[g*8 +: 8]];
			// manual requests come from same-clock logic, edge only
			assign req_new[g] = hw_req[g] |
				(chan_manual_req_i[g] & ~manual_prev_reg[g]);
			// set outranks retire so an event in the retiring cycle
			// is not lost; disabled or halted channels forget theirs
			assign pend_next[g] = chan_enable_i[g] & ~halt_reg[g] &
				(req_new[g] | (pend_reg[g] & ~retire_mask[g]));
		end
	endgenerate

	fdc_arbiter #(.CHANNELS(CH), .IW(IW)) u_arb (
		.pend_i(pend_reg & chan_enable_i),
		.grant_idx_o(grant_idx),
		.grant_valid_o(grant_valid)
	);

	// address generation for the channel in service
	always @* begin
		retire_mask = {CH{1'b0}};
		cur_byte = chan_byte_mode_i[cur_reg];
		cur_to_periph = chan_to_periph_i[cur_reg];
		cur_mode = chan_addr_mode_i[cur_reg*2 +: 2];
		cur_pad = channel_peripheral_address_i[cur_reg*AW +: AW];
		cnt_now = done_cnt_reg[cur_reg*CW +: CW];
		cnt_tot = chan_count_i[cur_reg*CW +: CW];
		// a byte element advances the address by one, a word by two
		step = cur_byte ? {{(AW-1){1'b0}}, 1'b1} :
			{{(AW-2){1'b0}}, 2'b10};
		sram_addr = (ping_reg[cur_reg] ?
			chan_sram_start_b_i[cur_reg*AW +: AW] :
			chan_sram_start_a_i[cur_reg*AW +: AW]);
		case (cur_mode)
		`FDC_AM_POSTINC: sram_addr = sram_addr +
			offs_reg[cur_reg*AW +: AW];
		`FDC_AM_NOINC: sram_addr = sram_addr;
		`FDC_AM_PERIPH: sram_addr = periph_supplied_addr_i;
		default: sram_addr = sram_addr;
		endcase
		// one direction per channel fixed by its config bit
		if (cur_to_periph) begin
			src_addr = sram_addr;
			dst_addr = cur_pad;
		end else begin
			src_addr = cur_pad;
			dst_addr = sram_addr;
		end
		// half mark is the floor of half the count, so a one-element
		// block never raises it
		elem_next = cnt_now + 1'b1;
		half_hit = chan_half_irq_i[cur_reg] &&
			(elem_next == {1'b0, cnt_tot[CW-1:1]});
		block_end = (elem_next == cnt_tot);
		offs_next = offs_reg[cur_reg*AW +: AW] + step;
		if (state_reg == `FDC_ST_DONE) begin
			retire_mask[cur_reg] = 1'b1;
		end
		fifo_push = (state_reg == `FDC_ST_READ) & mem_rd_o & mem_ack_i;
		fifo_pop = (state_reg == `FDC_ST_WRITE) & mem_wr_o & mem_ack_i;
	end

	// words pass through the fifo between read and write; a full fifo
	// stalls the read phase, which is the back-pressure path
	fdc_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.ce_i(ce_i),
		.in_data_i(mem_rdata_i),
		.in_valid_i(fifo_push),
		.in_ready_o(fifo_in_ready),
		.out_data_o(fifo_out_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_pop)
	);

	// request capture, arbitration and transfer sequence
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_reg <= `FDC_ST_IDLE;
			cur_reg <= {IW{1'b0}};
			pend_reg <= {CH{1'b0}};
			active_reg <= {CH{1'b0}};
			offs_reg <= {(CH*AW){1'b0}};
			done_cnt_reg <= {(CH*CW){1'b0}};
			ping_reg <= {CH{1'b0}};
			manual_prev_reg <= {CH{1'b0}};
			halt_reg <= {CH{1'b0}};
			mem_rd_o <= 1'b0;
			mem_wr_o <= 1'b0;
			mem_byte_o <= 1'b0;
			mem_addr_o <= {AW{1'b0}};
			mem_wdata_o <= {DW{1'b0}};
			chan_busy_o <= {CH{1'b0}};
			chan_half_irq_o <= {CH{1'b0}};
			chan_done_irq_o <= {CH{1'b0}};
			chan_ping_sel_o <= {CH{1'b0}};
		end else if (ce_i) begin
			manual_prev_reg <= chan_manual_req_i;
			chan_half_irq_o <= {CH{1'b0}};
			chan_done_irq_o <= {CH{1'b0}};
			chan_busy_o <= active_reg;
			chan_ping_sel_o <= ping_reg;
			// new requests join pending, set outranks retire
			pend_reg <= pend_next;
			// dropping a channel's enable re-arms a halted one-shot
			halt_reg <= halt_reg & chan_enable_i;
			case (state_reg)
			`FDC_ST_IDLE: begin
				if (grant_valid) begin
					cur_reg <= grant_idx;
					active_reg[grant_idx] <= 1'b1;
					state_reg <= `FDC_ST_READ;
				end
			end
			`FDC_ST_READ: begin
				if (mem_rd_o && mem_ack_i) begin
					mem_rd_o <= 1'b0;
					state_reg <= `FDC_ST_WRITE;
				end else if (!mem_rd_o && fifo_in_ready) begin
					mem_rd_o <= 1'b1;
					mem_byte_o <= chan_byte_mode_i[cur_reg];
					mem_addr_o <= src_addr;
				end
			end
			`FDC_ST_WRITE: begin
				if (mem_wr_o && mem_ack_i) begin
					mem_wr_o <= 1'b0;
					state_reg <= `FDC_ST_DONE;
				end else if (!mem_wr_o && fifo_out_valid) begin
					mem_wr_o <= 1'b1;
					mem_addr_o <= dst_addr;
					mem_wdata_o <= fifo_out_data;
				end
			end
			`FDC_ST_DONE: begin
				// one element moved: retire_mask consumes the request
				offs_reg[cur_reg*AW +: AW] <= offs_next;
				done_cnt_reg[cur_reg*CW +: CW] <= elem_next;
				if (half_hit) begin
					chan_half_irq_o[cur_reg] <= 1'b1;
				end
				if (block_end) begin
					chan_done_irq_o[cur_reg] <= 1'b1;
					offs_reg[cur_reg*AW +: AW] <= {AW{1'b0}};
					done_cnt_reg[cur_reg*CW +: CW] <= {CW{1'b0}};
					if (chan_ping_pong_i[cur_reg]) begin
						ping_reg[cur_reg] <= ~ping_reg[cur_reg];
					end
					// one-shot ends here, auto-repeat rearms
					active_reg[cur_reg] <= chan_auto_repeat_i[cur_reg];
					// halt stops later requests; one landing in this cycle still starts a second block
					if (!chan_auto_repeat_i[cur_reg]) begin
						halt_reg[cur_reg] <= 1'b1;
					end
				end
				state_reg <= `FDC_ST_IDLE;
			end
			default: state_reg <= `FDC_ST_IDLE;
			endcase
		end
	end
endmodule // fdc_dma

// File: core/fdc_fifo.v
// small synchronous fifo holding words between the read and write phases
module fdc_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire core_clk_i,
	input wire reset_i,
	input wire ce_i,
	input wire [WIDTH-1:0] in_data_i,
	input wire in_valid_i,
	output wire in_ready_o,
	output reg [WIDTH-1:0] out_data_o,
	output wire out_valid_o,
	input wire out_ready_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	reg out_valid_reg;
	wire push;
	wire pop;
	wire load;

	// fall-through register keeps read data registered at the output
	assign in_ready_o = (count_reg != DEPTH[AW:0]);
	assign out_valid_o = out_valid_reg;
	assign push = in_valid_i & in_ready_o;
	assign load = (count_reg != {(AW+1){1'b0}}) &
		(~out_valid_reg | out_ready_i);
	assign pop = out_valid_reg & out_ready_i;

	// storage array carries no reset; pointers, count and output stage do
	always @(posedge core_clk_i) begin
		if (ce_i && push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	// pointers, occupancy and output stage
	always @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
			out_valid_reg <= 1'b0;
			out_data_o <= {WIDTH{1'b0}};
		end else if (ce_i) begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (load) begin
				out_data_o <= mem[rd_ptr_reg];
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				out_valid_reg <= 1'b1;
			end else if (pop) begin
				out_valid_reg <= 1'b0;
			end
			count_reg <= count_reg + {{AW{1'b0}}, push} -
				{{AW{1'b0}}, load};
		end
	end
endmodule // fdc_fifo

// File: dv/fdc_dma_checker.sv
// port checks for the transfer controller
module fdc_dma_checker (
	input wire logic core_clk_i,
	input wire logic reset_i,
	input wire logic [3:0] chan_enable_i,
	input wire logic [3:0] chan_to_periph_i,
	input wire logic [3:0] chan_byte_mode_i,
	input wire logic [3:0] chan_manual_req_i,
	input wire logic [63:0] channel_peripheral_address_i,
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic mem_byte_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic mem_ack_i,
	input wire logic [3:0] chan_busy_o,
	input wire logic [3:0] chan_half_irq_o,
	input wire logic [3:0] chan_done_irq_o
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge core_clk_i); endclocking
default disable iff (reset_i);
a_one_dir: assert property (!(mem_rd_o && mem_wr_o))
	else $error("read and write at once");
a_rd_holds: assert property (mem_rd_o && !mem_ack_i |=>
	mem_rd_o && $stable(mem_addr_o)) else $error("read dropped early");
a_wr_holds: assert property (mem_wr_o && !mem_ack_i |=>
	mem_wr_o && $stable(mem_addr_o)) else $error("write dropped early");
a_src_periph: assert property (mem_rd_o && chan_busy_o == 4'h1 &&
	!chan_to_periph_i[0] |->
	mem_addr_o == channel_peripheral_address_i[15:0])
	else $error("read not from peripheral");
a_byte_flag: assert property ((mem_rd_o || mem_wr_o) &&
	chan_busy_o == 4'h2 |-> mem_byte_o == chan_byte_mode_i[1])
	else $error("byte flag wrong");
a_start_rd: assert property ($rose(chan_manual_req_i[0]) &&
	chan_enable_i[0] && chan_busy_o == 4'h0 && !mem_wr_o |->
	##[1:8] mem_rd_o) else $error("manual start not served");
a_done_pulse: assert property (chan_done_irq_o != 4'h0 |=>
	chan_done_irq_o == 4'h0) else $error("done pulse too long");
a_half_pulse: assert property (chan_half_irq_o != 4'h0 |=>
	chan_half_irq_o == 4'h0) else $error("half pulse too long");
endmodule // fdc_dma_checker
bind fdc_dma fdc_dma_checker u_chk (.core_clk_i(core_clk_i),
	.reset_i(reset_i), .chan_enable_i(chan_enable_i),
	.chan_to_periph_i(chan_to_periph_i),
	.chan_byte_mode_i(chan_byte_mode_i),
	.chan_manual_req_i(chan_manual_req_i),
	.channel_peripheral_address_i(channel_peripheral_address_i),
	.mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_byte_o(mem_byte_o),
	.mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
	.chan_busy_o(chan_busy_o), .chan_half_irq_o(chan_half_irq_o),
	.chan_done_irq_o(chan_done_irq_o));

// File: dv/fdc_mem_model.sv
// memory and peripheral bus partner with programmable wait states
module fdc_mem_model (
	input wire logic core_clk_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [1:0] wait_i,
	output logic ack_o,
	output logic [15:0] rdata_o
);
timeunit 1ns;
timeprecision 1ns;
logic [1:0] cnt = 2'h0;
logic [15:0] ra[$], wa[$], wd[$];
initial ack_o = 1'b0;
initial rdata_o = 16'h0;
// answer after wait_i cycles; data churns so stale values never match
always @(posedge core_clk_i) begin
	ack_o <= 1'b0;
	rdata_o <= ~rdata_o;
	if ((rd_i || wr_i) && !ack_o) begin
		if (cnt == wait_i) begin
			ack_o <= 1'b1;
			cnt <= 2'h0;
			if (rd_i) begin
				rdata_o <= addr_i ^ 16'h5a5a;
				ra.push_back(addr_i);
			end else begin
				wa.push_back(addr_i);
				wd.push_back(wdata_i);
			end
		end else
			cnt <= cnt + 2'h1;
	end
end
endmodule // fdc_mem_model

// File: dv/tb_fdc_dma.sv
// self-checking bench for the four-channel transfer controller
`include "fdc_consts.vh"
module tb_fdc_dma;
timeunit 1ns;
timeprecision 1ns;
logic clk = 1'b0, rst = 1'b1, ack, rd, wr, byt;
logic [3:0] en, tp, bm, ar, pp, mr, busy, hf, dn, ps, hie;
logic [7:0] am;
logic [31:0] sel;
logic [63:0] sa, sb, pa, cnt;
logic [255:0] src;
logic [15:0] psa, addr, wdat, rdat;
logic [1:0] wt;
int num_errors = 0, n_compared = 0, nh[4], nd[4];
// 25 MHz core clock
always #20 clk = ~clk;
fdc_dma DUT (.core_clk_i(clk), .reset_i(rst), .ce_i(1'b1),
	.chan_enable_i(en), .chan_to_periph_i(tp), .chan_byte_mode_i(bm),
	.chan_addr_mode_i(am), .chan_auto_repeat_i(ar), .chan_ping_pong_i(pp),
	.chan_half_irq_i(hie), .request_source_select_i(sel),
	.chan_sram_start_a_i(sa), .chan_sram_start_b_i(sb),
	.channel_peripheral_address_i(pa), .chan_count_i(cnt),
	.chan_manual_req_i(mr), .irq_src_i(src), .periph_supplied_addr_i(psa),
	.mem_rd_o(rd), .mem_wr_o(wr), .mem_byte_o(byt), .mem_addr_o(addr),
	.mem_wdata_o(wdat), .mem_rdata_i(rdat), .mem_ack_i(ack),
	.chan_busy_o(busy), .chan_half_irq_o(hf), .chan_done_irq_o(dn),
	.chan_ping_sel_o(ps));
fdc_mem_model M (.core_clk_i(clk), .rd_i(rd), .wr_i(wr), .addr_i(addr),
	.wdata_i(wdat), .wait_i(wt), .ack_o(ack), .rdata_o(rdat));
// tally interrupt pulses per channel
always @(posedge clk)
	for (int j = 0; j < 4; j++) begin
		nh[j] += hf[j];
		nd[j] += dn[j];
	end
task stop_test;
	$display("errors %0d compares %0d", num_errors, n_compared);
	if (num_errors == 0 && n_compared > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
task chk(input logic [15:0] g, e);
	n_compared++;
	if (g !== e) begin
		num_errors++;
		$display("Error at %0t: got %h expected %h", $time, g, e);
	end
endtask
task clr;
	M.ra.delete();
	M.wa.delete();
	M.wd.delete();
endtask
task cfg(input int c, input bit t, y, input logic [1:0] m,
	input bit r, p, input logic [7:0] s, input logic [15:0] a, b, d, n);
	@(negedge clk);
	// one cycle with the enable low re-arms a halted one-shot channel
	en[c] = 1'b0;
	@(negedge clk);
	{tp[c], bm[c], ar[c], pp[c], en[c]} = {t, y, r, p, 1'b1};
	am[c*2+:2] = m;
	sel[c*8+:8] = s;
	{sa[c*16+:16], sb[c*16+:16], pa[c*16+:16], cnt[c*16+:16]} = {a, b, d, n};
endtask
// raise a request, then wait for its writes to land (bounded)
task go(input logic [3:0] m, input logic [7:0] s, input bit man,
	input int n);
	int k;
	k = M.wa.size() + n;
	@(negedge clk);
	if (man)
		mr = m;
	else
		src[s] = 1'b1;
	repeat (2) @(negedge clk);
	mr = 4'h0;
	src = '0;
	for (int i = 0; i < 99 && M.wa.size() < k; i++) @(negedge clk);
	if (M.wa.size() < k) begin
		num_errors++;
		$display("Error at %0t: transfer timed out", $time);
	end
	// a refused request gets a longer quiet span to prove nothing moves
	repeat (n == 0 ? 20 : 6) @(negedge clk);
endtask
initial begin
	{en, tp, bm, ar, pp, mr, am, sel, sa, sb, pa, cnt, src, psa, wt} = '0;
	hie = 4'hf;
	repeat (5) @(negedge clk);
	rst = 1'b0;
	// one-shot word block from the capture buffer, manual starts
	cfg(0, 0, 0, `FDC_AM_POSTINC, 0, 0, `FDC_SRC_CAPTURE1, 16'h1000,
		16'h0, `FDC_ADDR_CAPTURE1, 16'h4);
	for (int i = 0; i < 4; i++) go(4'h1, 8'h0, 1, 1);
	for (int i = 0; i < 4; i++) begin
		chk(M.ra[i], `FDC_ADDR_CAPTURE1);
		chk(M.wa[i], 16'h1000 + 16'(2 * i));
		chk(M.wd[i], `FDC_ADDR_CAPTURE1 ^ 16'h5a5a);
	end
	chk(16'(nh[0]), 16'h1);
	chk(16'(nd[0]), 16'h1);
	chk({15'h0, busy[0]}, 16'h0);
	// byte ping-pong auto-repeat to the serial transmitter, slow memory
	clr();
	wt = 2'h2;
	cfg(1, 1, 1, `FDC_AM_NOINC, 1, 1, `FDC_SRC_SERIAL1_TX, 16'h2000,
		16'h3000, `FDC_ADDR_SERIAL1_TX, 16'h2);
	for (int i = 0; i < 4; i++) begin
		// second block runs with its half mark masked
		hie[1] = (i < 2);
		go(4'h2, `FDC_SRC_SERIAL1_TX, 0, 1);
	end
	for (int i = 0; i < 4; i++) begin
		chk(M.ra[i], i < 2 ? 16'h2000 : 16'h3000);
		chk(M.wa[i], `FDC_ADDR_SERIAL1_TX);
		chk({8'h0, M.wd[i][7:0]}, 16'h005a);
	end
	chk(16'(nd[1]), 16'h2);
	chk(16'(nh[1]), 16'h1);
	chk({15'h0, busy[1]}, 16'h1);
	chk({15'h0, ps[1]}, 16'h0);
	// simultaneous requests are served by channel number
	clr();
	en[1] = 1'b0;
	cfg(3, 0, 0, `FDC_AM_POSTINC, 0, 0, `FDC_SRC_CAN1_RX, 16'h5000,
		16'h0, `FDC_ADDR_CAN1_RX, 16'h1);
	cfg(2, 0, 0, `FDC_AM_POSTINC, 0, 0, `FDC_SRC_CONV_DONE, 16'h4000,
		16'h0, `FDC_ADDR_CONV_RES0, 16'h1);
	go(4'hc, 8'h0, 1, 2);
	chk(M.wa[0], 16'h4000);
	chk(M.ra[0], `FDC_ADDR_CONV_RES0);
	chk(M.wa[1], 16'h5000);
	// a disabled channel drops its request
	en[3] = 1'b0;
	go(4'h8, 8'h0, 1, 0);
	chk(16'(M.wa.size()), 16'h2);
	// a finished one-shot channel refuses a further request
	go(4'h4, 8'h0, 1, 0);
	chk(16'(M.wa.size()), 16'h2);
	// peripheral-indirect: receive data goes to the supplied address
	clr();
	psa = 16'h6000;
	cfg(0, 0, 0, `FDC_AM_PERIPH, 0, 0, `FDC_SRC_EXT_EXTERNAL_INTERRUPT0, 16'h0, 16'h0,
		`FDC_ADDR_SERIAL1_RX, 16'h1);
	go(4'h1, `FDC_SRC_EXT_EXTERNAL_INTERRUPT0, 0, 1);
	chk(M.wa[0], 16'h6000);
	chk(M.ra[0], `FDC_ADDR_SERIAL1_RX);
	stop_test();
end
// watchdog far beyond the expected run length
initial begin
	#400000;
	num_errors++;
	stop_test();
end
endmodule // tb_fdc_dma
